// file: rtl/eal_loader.sv
// EEPROM register autoloader: signature check, sequential load, auto mode.
// Assumes link_clk is free running; the EEPROM sits at chip address zero.
`timescale 1ns/1ps

// Notes on behaviour
// - Only a serial clock output and one two-way data line reach the EEPROM.
// - Works with a 512x8 two-wire EEPROM.
// - Loaded words initialise configuration registers before enumeration.
// - Automatic load starts only after primary reset is released.
// - Contents are 16-bit words; each access sends a 7-bit word address.
// - Part is always addressed as chip zero; board straps its address pins low.
// - Auto mode runs whole one-word accesses in hardware on request.
// - Software supplies start, word address and read or write selection.
// - Word at offset zero is read first as the signature.
// - Matching signature starts the load at once; mismatch skips it.
// - Load fetches words in ascending order into their registers.
// - Busy status reads 1 during load and 0 when complete.
// - Word 06h loads VC count, link capability, switch mode and pin settings.
// - Word 0Ch loads payload size, power management and error reporting.
// - Words 20h to 26h load per-port training, scrambling, control, deskew.
// - Words 40h to 44h load per-port de-emphasis, rate count, parameters.
module eal_loader #(
    parameter logic [15:0] SIG_VALUE = 16'h5A5A,
    parameter int WRITE_CYC = eal_pkg::WRITE_CYC_DFLT,
    parameter int QUARTER_CYCLES = eal_pkg::QUARTER_CYC
) (
    // Clocks and reset
    input wire logic mclk,
    input wire logic nrst,
    input wire logic link_clk,
    // Auto mode control and status
    input wire logic auto_start,
    input wire logic auto_write,
    input wire logic [eal_pkg::WORD_AW-1:0] auto_word_addr,
    input wire logic [15:0] auto_wdata,
    output logic autoload_busy,
    output logic auto_busy,
    output logic [15:0] auto_rdata,
    output logic auto_nack,
    // Loaded configuration
    output eal_pkg::eal_cfg_t cfg,
    // EEPROM pins
    output logic eeprom_serial_clock,
    input wire logic eeprom_serial_data_in,
    output logic eeprom_serial_data_out,
    output logic eeprom_serial_data_oe
);
    import eal_pkg::*;

    typedef enum {M_BOOT, M_SIG, M_LOAD, M_IDLE, M_AUTO} eal_mstate_t;
    typedef enum {L_IDLE, L_RUN} eal_lstate_t;
    typedef enum {IT_START, IT_TX, IT_RX_ACK, IT_RX_NACK, IT_STOP, IT_WAIT, IT_END} eal_item_t;

    // ****************************************
    // Functions
    // ****************************************
    function automatic int cfg_slot(input logic [WORD_AW-1:0] w);
        cfg_slot = -1;
        case (w)
            OFS_VENDOR[7:1]: cfg_slot = 0;
            OFS_DEVICE[7:1]: cfg_slot = 1;
            OFS_MODE[7:1]: cfg_slot = 2;
            OFS_SUB_VENDOR[7:1]: cfg_slot = 3;
            OFS_SUB_ID[7:1]: cfg_slot = 4;
            OFS_CAP[7:1]: cfg_slot = 5;
            default: begin
                if (w >= OFS_PORT_PHY[7:1] && w < OFS_PORT_PHY[7:1] + PHY_PORTS) begin
                    cfg_slot = SLOT_PHY + int'(w - OFS_PORT_PHY[7:1]);
                end else if (w >= OFS_PORT_RATE[7:1] && w <= OFS_LAST[7:1]) begin
                    cfg_slot = SLOT_RATE + int'(w - OFS_PORT_RATE[7:1]);
                end
            end
        endcase
    endfunction

    function automatic eal_item_t item_kind(input logic wr, input logic [3:0] idx);
        item_kind = IT_END;
        if (wr) begin
            case (idx)
                4'h0: item_kind = IT_START;
                4'h1, 4'h2, 4'h3, 4'h4: item_kind = IT_TX;
                4'h5: item_kind = IT_STOP;
                4'h6: item_kind = IT_WAIT;
                default: item_kind = IT_END;
            endcase
        end else begin
            case (idx)
                4'h0, 4'h3: item_kind = IT_START;
                4'h1, 4'h2, 4'h4: item_kind = IT_TX;
                4'h5: item_kind = IT_RX_ACK;
                4'h6: item_kind = IT_RX_NACK;
                4'h7: item_kind = IT_STOP;
                default: item_kind = IT_END;
            endcase
        end
    endfunction

    function automatic logic [7:0] tx_byte(input eal_cmd_t c, input logic [3:0] idx);
        tx_byte = 8'hFF;
        case (idx)
            4'h1: tx_byte = {CTRL_FAMILY, CHIP_ADDR, PAGE_BIT, 1'h0};
            4'h2: tx_byte = {c.addr, 1'h0};
            4'h3: tx_byte = c.wdata[7:0];
            4'h4: tx_byte = c.write ? c.wdata[15:8] : {CTRL_FAMILY, CHIP_ADDR, PAGE_BIT, 1'h1};
            default: tx_byte = 8'hFF;
        endcase
    endfunction

    // ****************************************
    // Reset release per domain
    // ****************************************
    logic [1:0] rst_m_r;
    logic [1:0] rst_l_r;
    logic rst_m_n;
    logic rst_l_n;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_m_r <= 2'h0;
        end else begin
            rst_m_r <= {rst_m_r[0], 1'h1};
        end
    end

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            rst_l_r <= 2'h0;
        end else begin
            rst_l_r <= {rst_l_r[0], 1'h1};
        end
    end

    assign rst_m_n = rst_m_r[1];
    assign rst_l_n = rst_l_r[1];

    // ****************************************
    // Core side sequencer
    // ****************************************
    eal_mstate_t mstate_r, mstate_nxt;
    eal_cmd_t cmd_r, cmd_nxt;
    logic req_tgl_r;
    logic issue;
    logic done_s;
    logic done_last_r;
    logic done_evt;
    logic [WORD_AW-1:0] word_r, word_nxt;
    eal_rsp_t rsp_r;
    logic [15:0] cfg_r [SLOTS];

    assign done_evt = done_s != done_last_r;

    always_comb begin
        mstate_nxt = mstate_r;
        cmd_nxt = cmd_r;
        word_nxt = word_r;
        issue = 1'b0;
        case (mstate_r)
            M_BOOT: begin
                // Boot read only after reset release
                cmd_nxt = '{write: 1'b0, addr: OFS_SIG[7:1], wdata: 16'h0000};
                issue = 1'b1;
                mstate_nxt = M_SIG;
            end
            M_SIG: begin
                if (done_evt) begin
                    if (rsp_r.rdata == SIG_VALUE) begin
                        word_nxt = OFS_VENDOR[7:1];
                        cmd_nxt.addr = OFS_VENDOR[7:1];
                        issue = 1'b1;
                        mstate_nxt = M_LOAD;
                    end else begin
                        mstate_nxt = M_IDLE;
                    end
                end
            end
            M_LOAD: begin
                if (done_evt) begin
                    if (word_r == OFS_LAST[7:1]) begin
                        mstate_nxt = M_IDLE;
                    end else begin
                        word_nxt = word_r + 7'h01;
                        cmd_nxt.addr = word_nxt;
                        issue = 1'b1;
                    end
                end
            end
            M_IDLE: begin
                // Starts while busy are not seen here
                if (auto_start) begin
                    cmd_nxt = '{write: auto_write, addr: auto_word_addr, wdata: auto_wdata};
                    issue = 1'b1;
                    mstate_nxt = M_AUTO;
                end
            end
            M_AUTO: begin
                if (done_evt) begin
                    mstate_nxt = M_IDLE;
                end
            end
            default: mstate_nxt = M_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_m_n) begin
        if (!rst_m_n) begin
            mstate_r <= M_BOOT;
            word_r <= '0;
        end else begin
            mstate_r <= mstate_nxt;
            word_r <= word_nxt;
        end
    end

    // Command held steady until the link answers
    always_ff @(posedge mclk or negedge rst_m_n) begin
        if (!rst_m_n) begin
            cmd_r <= '0;
            req_tgl_r <= 1'b0;
            done_last_r <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            done_last_r <= done_s;
            if (issue) begin
                req_tgl_r <= ~req_tgl_r;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_m_n) begin
        if (!rst_m_n) begin
            for (int i = 0; i < SLOTS; i++) begin
                cfg_r[i] <= CFG_RESET;
            end
        end else if (mstate_r == M_LOAD && done_evt && cfg_slot(word_r) >= 0) begin
            cfg_r[cfg_slot(word_r)] <= rsp_r.rdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_m_n) begin
        if (!rst_m_n) begin
            auto_rdata <= 16'h0000;
            auto_nack <= 1'b0;
        end else if (mstate_r == M_AUTO && done_evt) begin
            auto_nack <= rsp_r.nack;
            if (!cmd_r.write) begin
                auto_rdata <= rsp_r.rdata;
            end
        end
    end

    assign autoload_busy = mstate_r == M_BOOT || mstate_r == M_SIG || mstate_r == M_LOAD;
    assign auto_busy = mstate_r != M_IDLE;

    always_comb begin
        cfg.vendor_id = cfg_r[0];
        cfg.device_id = cfg_r[1];
        cfg.mode_word = cfg_r[2];
        cfg.sub_vendor_id = cfg_r[3];
        cfg.sub_id = cfg_r[4];
        cfg.cap_word = cfg_r[5];
        for (int p = 0; p < PHY_PORTS; p++) begin
            cfg.port_phy[p] = cfg_r[SLOT_PHY + p];
        end
        for (int p = 0; p < RATE_PORTS; p++) begin
            cfg.port_rate[p] = cfg_r[SLOT_RATE + p];
        end
    end

    // ****************************************
    // Link side bit engine
    // ****************************************
    eal_lstate_t lstate_r;
    eal_cmd_t lcmd_r;
    logic req_s;
    logic req_last_r;
    logic done_tgl_r;
    logic sda_in_s;
    logic [3:0] item_r;
    logic [3:0] bit_r;
    logic [1:0] q_r;
    logic [7:0] qcnt_r;
    logic [31:0] wcnt_r;
    logic [7:0] sh_r;
    logic scl_c;
    logic sda_c;
    logic tick;
    eal_item_t kind;

    eal_sync #(.STAGES(SYNC_STAGES)) u_req_sync (.clk(link_clk), .rst_n(rst_l_n), .d(req_tgl_r), .q(req_s));
    eal_sync #(.STAGES(SYNC_STAGES)) u_done_sync (.clk(mclk), .rst_n(rst_m_n), .d(done_tgl_r), .q(done_s));
    eal_sync #(.STAGES(PIN_STAGES)) u_sda_sync (.clk(link_clk), .rst_n(rst_l_n),
        .d(eeprom_serial_data_in), .q(sda_in_s));

    assign kind = lstate_r == L_RUN ? item_kind(lcmd_r.write, item_r) : IT_END;
    assign tick = qcnt_r == 8'(QUARTER_CYCLES - 1);

    // Quarter phases: data moves while clock low, sampled while high
    always_comb begin
        scl_c = 1'b1;
        sda_c = 1'b1;
        case (kind)
            IT_START: begin
                scl_c = q_r == 2'h1 || q_r == 2'h2;
                sda_c = q_r < 2'h2;
            end
            IT_STOP: begin
                scl_c = q_r != 2'h0;
                sda_c = q_r[1];
            end
            IT_TX: begin
                scl_c = q_r[1];
                sda_c = bit_r == 4'h8 ? 1'b1 : sh_r[7];
            end
            IT_RX_ACK: begin
                scl_c = q_r[1];
                sda_c = bit_r != 4'h8;
            end
            IT_RX_NACK: scl_c = q_r[1];
            default: scl_c = 1'b1;
        endcase
    end

    // Open drain data: drive only a low
    always_ff @(posedge link_clk or negedge rst_l_n) begin
        if (!rst_l_n) begin
            eeprom_serial_clock <= 1'b1;
            eeprom_serial_data_oe <= 1'b0;
        end else begin
            eeprom_serial_clock <= scl_c;
            eeprom_serial_data_oe <= ~sda_c;
        end
    end
    assign eeprom_serial_data_out = 1'b0;

    always_ff @(posedge link_clk or negedge rst_l_n) begin
        if (!rst_l_n) begin
            qcnt_r <= 8'h00;
            q_r <= 2'h0;
        end else if (lstate_r != L_RUN || tick || kind == IT_WAIT) begin
            qcnt_r <= 8'h00;
            q_r <= (lstate_r == L_RUN && tick) ? q_r + 2'h1 : 2'h0;
        end else begin
            qcnt_r <= qcnt_r + 8'h01;
        end
    end

    always_ff @(posedge link_clk or negedge rst_l_n) begin
        if (!rst_l_n) begin
            lstate_r <= L_IDLE;
            lcmd_r <= '0;
            req_last_r <= 1'b0;
            done_tgl_r <= 1'b0;
            item_r <= 4'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            wcnt_r <= 32'h0;
            rsp_r <= '0;
        end else if (lstate_r == L_IDLE) begin
            if (req_s != req_last_r) begin
                req_last_r <= req_s;
                lcmd_r <= cmd_r;
                lstate_r <= L_RUN;
                item_r <= 4'h0;
                bit_r <= 4'h0;
                rsp_r.nack <= 1'b0;
            end
        end else if (kind == IT_END) begin
            done_tgl_r <= ~done_tgl_r;
            lstate_r <= L_IDLE;
        end else if (kind == IT_WAIT) begin
            // Internal write cycle of the part
            wcnt_r <= wcnt_r + 32'h1;
            if (wcnt_r == 32'(WRITE_CYC - 1)) begin
                wcnt_r <= 32'h0;
                item_r <= item_r + 4'h1;
            end
        end else if (tick && q_r == 2'h2 && bit_r != 4'h8 && kind != IT_TX) begin
            sh_r <= {sh_r[6:0], sda_in_s};
        end else if (tick && q_r == 2'h2 && bit_r == 4'h8 && kind == IT_TX) begin
            rsp_r.nack <= rsp_r.nack | sda_in_s;
        end else if (tick && q_r == 2'h3) begin
            if (kind == IT_START || kind == IT_STOP || bit_r == 4'h8) begin
                item_r <= item_r + 4'h1;
                bit_r <= 4'h0;
                sh_r <= tx_byte(lcmd_r, item_r + 4'h1);
                if (kind == IT_RX_ACK) begin
                    rsp_r.rdata[7:0] <= sh_r;
                end
                if (kind == IT_RX_NACK) begin
                    rsp_r.rdata[15:8] <= sh_r;
                end
            end else begin
                bit_r <= bit_r + 4'h1;
                if (kind == IT_TX) begin
                    sh_r <= {sh_r[6:0], 1'b0};
                end
            end
        end
    end
endmodule

// file: rtl/eal_sync.sv
// Bit synchroniser for the autoloader's clock crossings and pin input.
// Assumes d is stable long enough to be seen; rst_n is already synchronous.
`timescale 1ns/1ps
module eal_sync #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic d,
    output logic q
);
    logic [STAGES-1:0] sh_r;
    logic q_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_r <= '0;
        end else begin
            sh_r <= {sh_r[STAGES-2:0], d};
        end
    end

    // Three stages: change taken only once stages two and three agree
    generate
        if (STAGES > 2) begin : g_agree
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    q_r <= 1'b0;
                end else if (sh_r[1] == sh_r[2]) begin
                    q_r <= sh_r[2];
                end
            end
            assign q = q_r;
        end else begin : g_plain
            assign q_r = 1'b0;
            assign q = sh_r[STAGES-1];
        end
    endgenerate
endmodule

// file: shared/eal_pkg.sv
// Constants and carrier types for the EEPROM register autoloader.
// Assumes a two-wire EEPROM strapped to chip address zero.
package eal_pkg;
    // ****************************************
    // EEPROM framing
    // ****************************************
    localparam int WORD_AW = 7;
    localparam logic [3:0] CTRL_FAMILY = 4'hA;
    localparam logic [1:0] CHIP_ADDR = 2'h0;
    localparam logic PAGE_BIT = 1'h0;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // ****************************************
    // Byte offsets of loaded words
    // ****************************************
    localparam logic [7:0] OFS_SIG = 8'h00;
    localparam logic [7:0] OFS_VENDOR = 8'h02;
    localparam logic [7:0] OFS_DEVICE = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h06;
    localparam logic [7:0] OFS_SUB_VENDOR = 8'h08;
    localparam logic [7:0] OFS_SUB_ID = 8'h0A;
    localparam logic [7:0] OFS_CAP = 8'h0C;
    localparam logic [7:0] OFS_PORT_PHY = 8'h20;
    localparam logic [7:0] OFS_PORT_RATE = 8'h40;
    localparam logic [7:0] OFS_LAST = 8'h44;
    localparam int PHY_PORTS = 4;
    localparam int RATE_PORTS = 3;
    localparam int SLOTS = 13;
    localparam int SLOT_PHY = 6;
    localparam int SLOT_RATE = 10;
    // Status bit that software polls
    localparam logic [7:0] OFS_STATUS = 8'hDC;
    localparam int STATUS_BUSY_BIT = 3;

    // ****************************************
    // Link timing
    // ****************************************
    localparam int LINK_PERIOD_NS = 48;
    localparam int QUARTER_NS = 2500;
    localparam int QUARTER_CYC = (QUARTER_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int WRITE_CYCLE_NS = 5000000;
    localparam int WRITE_CYC_DFLT = WRITE_CYCLE_NS / LINK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;
    localparam int PIN_STAGES = 3;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic write;
        logic [WORD_AW-1:0] addr;
        logic [15:0] wdata;
    } eal_cmd_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic nack;
    } eal_rsp_t;

    typedef struct packed {
        logic [7:0] fts_count;
        logic scramble_off;
        logic [5:0] phy_link_control_field;
        logic deskew_mode;
    } eal_port_phy_t;

    typedef struct packed {
        logic [15:0] vendor_id;
        logic [15:0] device_id;
        logic [15:0] sub_vendor_id;
        logic [15:0] sub_id;
        logic [15:0] mode_word;
        logic [15:0] cap_word;
        eal_port_phy_t [PHY_PORTS-1:0] port_phy;
        logic [RATE_PORTS-1:0][15:0] port_rate;
    } eal_cfg_t;
endpackage

// file: verification/eal_eeprom_model.sv
// Behavioural two-wire EEPROM of 512 bytes at chip address zero.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module eal_eeprom_model (
    // Pins
    input wire logic scl,
    input wire logic sda,
    output logic pull_low
);
    import eal_pkg::*;
    logic [7:0] mem [512];
    logic [7:0] sh;
    logic [8:0] ptr = 9'h000;
    int bc = 0;
    int phase = 0;
    logic act = 1'h0;
    logic tx = 1'h0;
    logic mute = 1'h0;
    initial pull_low = 1'h0;
    // ****
    // Start and stop
    // ****
    always @(negedge sda) begin
        if (scl === 1'h1) begin
            act = 1'h1;
            tx = 1'h0;
            bc = 0;
            phase = 0;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'h1) begin
            act = 1'h0;
            tx = 1'h0;
        end
    end
    // ****
    // Bits and acknowledge
    // ****
    always @(posedge scl) begin
        if (act && bc < 8) begin
            sh = {sh[6:0], sda};
            bc = bc + 1;
        end else if (act) begin
            bc = 9;
            if (tx && phase == 3) begin
                ptr = ptr + 9'h001;
                act = !sda;
            end
        end
    end
    always @(negedge scl) begin
        if (act && bc == 8) begin
            pull_low = 1'h0;
            if (!tx) begin
                // Only chip zero answers: address pins strapped low
                if (phase == 0 && sh[7:2] == {CTRL_FAMILY, 2'h0} && !mute) begin
                    ptr[8] = sh[1];
                    tx = sh[0];
                    phase = 1;
                    pull_low = 1'h1;
                end else if (phase == 1) begin
                    ptr[7:0] = sh;
                    phase = 2;
                    pull_low = 1'h1;
                end else if (phase == 2) begin
                    mem[ptr] = sh;
                    ptr[7:0] = ptr[7:0] + 8'h01;
                    pull_low = 1'h1;
                end else begin
                    act = 1'h0;
                end
            end
        end else if (act && bc == 9) begin
            bc = 0;
            phase = tx ? 3 : phase;
            pull_low = tx & ~mem[ptr][7];
        end else if (act && tx) begin
            pull_low = ~mem[ptr][7-bc];
        end
    end
endmodule

// file: verification/eal_loader_props.sv
// Concurrent checks on the autoloader's top-level ports.
// Assumes it is bound to eal_loader and sees nothing else.
`timescale 1ns/1ps
module eal_loader_props #(
    parameter int WRITE_CYC = 20
) (
    // Clocks and reset
    input wire logic mclk,
    input wire logic nrst,
    input wire logic link_clk,
    // Auto mode
    input wire logic auto_start,
    input wire logic auto_write,
    input wire logic [eal_pkg::WORD_AW-1:0] auto_word_addr,
    input wire logic [15:0] auto_wdata,
    input wire logic autoload_busy,
    input wire logic auto_busy,
    input wire logic [15:0] auto_rdata,
    input wire logic auto_nack,
    // Configuration and pins
    input wire eal_pkg::eal_cfg_t cfg,
    input wire logic eeprom_serial_clock,
    input wire logic eeprom_serial_data_in,
    input wire logic eeprom_serial_data_out,
    input wire logic eeprom_serial_data_oe
);
    import eal_pkg::*;
    a_pin_open_drain: assert property (@(posedge link_clk) disable iff (!nrst) eeprom_serial_data_out == 1'h0)
        else $error("data pin driven high");
    a_boot_busy_set: assert property (@(posedge mclk) disable iff (!nrst) $rose(nrst) |-> autoload_busy && auto_busy)
        else $error("load not pending after reset");
    a_load_in_seq: assert property (@(posedge mclk) disable iff (!nrst) autoload_busy |-> auto_busy)
        else $error("load busy without sequencer busy");
    a_load_only_once: assert property (@(posedge mclk) disable iff (!nrst) !autoload_busy |=> !autoload_busy)
        else $error("load restarted without reset");
    a_cfg_frozen: assert property (@(posedge mclk) disable iff (!nrst) !autoload_busy |=> $stable(cfg))
        else $error("cfg changed after load");
    a_rdata_held: assert property (@(posedge mclk) disable iff (!nrst)
        !$fell(auto_busy) |-> $stable({auto_rdata, auto_nack}))
        else $error("result changed outside completion");
    a_start_taken: assert property (@(posedge mclk) disable iff (!nrst) auto_start && !auto_busy |=> auto_busy)
        else $error("idle start not taken");
    a_idle_lines: assert property (@(posedge mclk) disable iff (!nrst)
        !auto_busy |-> eeprom_serial_clock && !eeprom_serial_data_oe)
        else $error("serial lines not idle");
    a_data_steady: assert property (@(posedge link_clk) disable iff (!nrst)
        $rose(eeprom_serial_clock) |-> $stable(eeprom_serial_data_oe))
        else $error("data moved with clock rise");
    a_low_phase: assert property (@(posedge link_clk) disable iff (!nrst)
        $fell(eeprom_serial_clock) |=> !eeprom_serial_clock [*8])
        else $error("serial clock low too short");
endmodule

bind eal_loader eal_loader_props #(.WRITE_CYC(WRITE_CYC)) u_props (
    .mclk(mclk), .nrst(nrst), .link_clk(link_clk), .auto_start(auto_start),
    .auto_write(auto_write), .auto_word_addr(auto_word_addr), .auto_wdata(auto_wdata),
    .autoload_busy(autoload_busy), .auto_busy(auto_busy), .auto_rdata(auto_rdata),
    .auto_nack(auto_nack), .cfg(cfg), .eeprom_serial_clock(eeprom_serial_clock),
    .eeprom_serial_data_in(eeprom_serial_data_in), .eeprom_serial_data_out(eeprom_serial_data_out),
    .eeprom_serial_data_oe(eeprom_serial_data_oe)
);

// file: verification/tb_eeprom_register_autoloader.sv
// Self-checking bench for the EEPROM register autoloader.
// Assumes the EEPROM model and a pull-up on the data wire.
`timescale 1ns/1ps
module tb_eeprom_register_autoloader;
    import eal_pkg::*;
    localparam logic [15:0] SIG = 16'h5A5A;
    logic mclk, nrst, link_clk, auto_start, auto_write, autoload_busy, auto_busy, auto_nack;
    logic [WORD_AW-1:0] auto_word_addr;
    logic [15:0] auto_wdata, auto_rdata;
    logic scl, sda_oe, sda_out, pull_low;
    eal_cfg_t cfg;
    wire sda = (sda_oe | pull_low) ? 1'h0 : 1'h1;
    int n_mismatch = 0;
    int num_checks = 0;

    eal_loader #(.SIG_VALUE(SIG), .WRITE_CYC(20), .QUARTER_CYCLES(9)) dut (
        .mclk(mclk), .nrst(nrst), .link_clk(link_clk), .auto_start(auto_start),
        .auto_write(auto_write), .auto_word_addr(auto_word_addr), .auto_wdata(auto_wdata),
        .autoload_busy(autoload_busy), .auto_busy(auto_busy), .auto_rdata(auto_rdata),
        .auto_nack(auto_nack), .cfg(cfg), .eeprom_serial_clock(scl),
        .eeprom_serial_data_in(sda), .eeprom_serial_data_out(sda_out), .eeprom_serial_data_oe(sda_oe)
    );
    eal_eeprom_model eeprom (.scl(scl), .sda(sda), .pull_low(pull_low));

    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'h0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    function automatic logic [7:0] pat(input int i);
        return i[7:0] ^ 8'hC3;
    endfunction
    function automatic logic [15:0] pw(input int o);
        return {pat(o + 1), pat(o)};
    endfunction

    task automatic chk(input string nm, input logic [207:0] exp, input logic [207:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        while (auto_busy !== 1'h0 && k < lim) begin
            @(negedge mclk);
            k++;
        end
        if (k >= lim) begin
            $display("[ERR] auto_busy expected 0 seen %b", auto_busy);
            n_mismatch++;
        end
    endtask
    task automatic issue(input logic wr, input logic [6:0] a, input logic [15:0] d);
        @(negedge mclk);
        auto_write = wr;
        auto_word_addr = a;
        auto_wdata = d;
        auto_start = 1'h1;
        @(negedge mclk);
        auto_start = 1'h0;
    endtask
    task automatic do_reset;
        nrst = 1'h0;
        repeat (10) @(negedge mclk);
        nrst = 1'h1;
        repeat (3) @(negedge mclk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        nrst = 1'h0;
        auto_start = 1'h0;
        auto_write = 1'h0;
        auto_word_addr = '0;
        auto_wdata = '0;
        for (int i = 0; i < 512; i++) eeprom.mem[i] = pat(i);
        // Pattern-filled part: signature word does not match
        do_reset();
        chk("autoload_busy", 1, autoload_busy);
        wait_idle(40000);
        chk("autoload_busy", 0, autoload_busy);
        chk("cfg", '0, cfg);
        $display("test bad_signature done");
        // Program the signature through auto mode
        issue(1'h1, 7'h00, SIG);
        wait_idle(40000);
        issue(1'h1, 7'h7F, 16'hBEEF);
        wait_idle(40000);
        chk("eeprom word 7F", 16'hBEEF, {eeprom.mem[255], eeprom.mem[254]});
        chk("eeprom word 00", SIG, {eeprom.mem[1], eeprom.mem[0]});
        issue(1'h0, 7'h11, 16'h0000);
        wait_idle(40000);
        chk("auto_rdata", pw(34), auto_rdata);
        chk("auto_nack", 0, auto_nack);
        // Start while busy must be ignored
        issue(1'h0, 7'h7F, 16'h0000);
        repeat (4) @(negedge mclk);
        issue(1'h1, 7'h7F, 16'h0000);
        wait_idle(40000);
        chk("auto_rdata", 16'hBEEF, auto_rdata);
        chk("eeprom word 7F", 16'hBEEF, {eeprom.mem[255], eeprom.mem[254]});
        chk("cfg", '0, cfg);
        eeprom.mute = 1'h1;
        issue(1'h0, 7'h01, 16'h0000);
        wait_idle(40000);
        chk("nack read", {1'h1, 16'hFFFF}, {auto_nack, auto_rdata});
        eeprom.mute = 1'h0;
        $display("test auto_mode done");
        // Signature now matches: full load
        do_reset();
        chk("autoload_busy", 1, autoload_busy);
        wait_idle(80000);
        chk("autoload_busy", 0, autoload_busy);
        chk("ids", {pw(2), pw(4), pw(8), pw(10)}, {cfg.vendor_id, cfg.device_id, cfg.sub_vendor_id, cfg.sub_id});
        chk("mode_word", pw(6), cfg.mode_word);
        chk("cap_word", pw(12), cfg.cap_word);
        chk("port_phy", {pw(38), pw(36), pw(34), pw(32)}, cfg.port_phy);
        chk("port_rate", {pw(68), pw(66), pw(64)}, cfg.port_rate);
        issue(1'h0, 7'h00, 16'h0000);
        wait_idle(40000);
        chk("auto_rdata", SIG, auto_rdata);
        $display("test full_load done");
        report_and_stop();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        $display("[ERR] watchdog expected finish seen hang");
        n_mismatch++;
        report_and_stop();
    end
endmodule
